// file: fir_defines.vh
`ifndef FIR_DEFINES_VH
`define FIR_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define FIR_ADR_CTRL       8'h00
`define FIR_ADR_MAP_LO     8'h04
`define FIR_ADR_MAP_HI     8'h08
`define FIR_ADR_DIAG0      8'h0c
`define FIR_ADR_DIAG1      8'h10
`define FIR_ADR_DIAG2      8'h14
`define FIR_ADR_DIAG3      8'h18
`define FIR_ADR_STATUS     8'h1c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FIR_CTRL_DIAG_EN   0
`define FIR_CTRL_PROC_EN   1
`define FIR_MAP_FALL_BIT   5
`define FIR_STAT_LOST_BIT  5

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define FIR_CTRL_RESET     2'h0
`define FIR_MAP_RESET      32'h0000_0000
`define FIR_MODULE_TYPE    4'h8
`define FIR_KIND_INTERNAL  3'h1
`define FIR_KIND_EXTERNAL  3'h2
`define FIR_QUEUE_DEPTH    8
`define FIR_SLOTS          8

`endif

// file: fir_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// controller cpu: runs each handler for wait_i + 1 cycles, then exits
module fir_host_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [3:0] wait_i,
  input  wire logic       diag_irq_i,
  input  wire logic       proc_irq_i,
  output var  logic       diag_exit_o = 1'b0,
  output var  logic       proc_exit_o = 1'b0
);
  logic [3:0] dcnt_reg = 4'h0;
  logic [3:0] pcnt_reg = 4'h0;

  // handlers use only the start information, never the generic record read
  always @(posedge clk_i) begin
    diag_exit_o <= 1'b0;
    proc_exit_o <= 1'b0;
    if (rst_i || !run_i) begin
      dcnt_reg <= 4'h0;
      pcnt_reg <= 4'h0;
    end else begin
      // skip the cycle after an exit so the device can move on
      if (diag_irq_i && !diag_exit_o) begin
        dcnt_reg <= (dcnt_reg == wait_i) ? 4'h0 : dcnt_reg + 4'h1;
        diag_exit_o <= (dcnt_reg == wait_i);
      end
      // only the head entry is serviced, one at a time, oldest first
      if (proc_irq_i && !proc_exit_o) begin
        pcnt_reg <= (pcnt_reg == wait_i) ? 4'h0 : pcnt_reg + 4'h1;
        proc_exit_o <= (pcnt_reg == wait_i);
      end
    end
  end
endmodule // fir_host_model

`default_nettype wire

// file: fir_queue.v
`timescale 1ns/1ps
`default_nettype none

// pending process interrupts, oldest first
module fir_queue (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       push_i,
  input  wire [2:0] data_i,
  input  wire       pop_i,
  output wire [2:0] head_o,
  output wire       empty_o,
  output wire       full_o,
  output wire [3:0] count_o
);

  reg [2:0] mem [0:7];
  reg [2:0] wr_reg;
  reg [2:0] rd_reg;
  reg [3:0] count_reg;
  wire      do_push;
  wire      do_pop;

  assign empty_o = (count_reg == 4'h0);
  assign full_o  = (count_reg == 4'h8);
  assign do_push = push_i & ~full_o;
  assign do_pop  = pop_i & ~empty_o;
  assign head_o  = mem[rd_reg];
  assign count_o = count_reg;

  always @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_reg] <= data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_reg    <= 3'h0;
      rd_reg    <= 3'h0;
      count_reg <= 4'h0;
    end else begin
      if (do_push) begin
        wr_reg <= wr_reg + 3'h1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 3'h1;
      end
      if (do_push & ~do_pop) begin
        count_reg <= count_reg + 4'h1;
      end else if (do_pop & ~do_push) begin
        count_reg <= count_reg - 4'h1;
      end
    end
  end

endmodule // fir_queue

`default_nettype wire

// file: fir_reporter.v
`timescale 1ns/1ps
`default_nettype none
`include "fir_defines.vh"

module fir_reporter (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  output wire [31:0] dat_o,
  input  wire        we_i,
  input  wire [3:0]  sel_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  output wire        ack_o,
  input  wire [7:0]  internal_fault_i,
  input  wire [7:0]  external_fault_i,
  input  wire [7:0]  handling_error_i,
  input  wire [7:0]  status_bit_i,
  input  wire        supply_short_i,
  input  wire        pkt_valid_i,
  input  wire        pkt_plausible_i,
  input  wire        cmd_valid_i,
  input  wire        cmd_allowed_i,
  output wire        pkt_accept_o,
  output wire        data_error_o,
  output wire        cmd_execute_o,
  output wire        operating_error_o,
  output wire        diag_irq_o,
  input  wire        diag_handler_exit_i,
  output wire [31:0] handler_diag_bytes_o,
  output wire        proc_irq_o,
  input  wire        proc_handler_exit_i,
  output wire [2:0]  trigger_channel_field_o,
  output wire        group_fault_lamp_o
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_PEND = 2'b10;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [1:0]  ctrl_reg;
  reg [31:0] map_lo_reg;
  reg [31:0] map_hi_reg;
  reg        ack_reg;
  reg [31:0] rdata_reg;
  reg [1:0]  dstate_reg;
  reg [1:0]  dstate_next;
  reg        dirty_reg;
  reg        lost_reg;
  reg [15:0] fault_prev_reg;
  reg [7:0]  code_reg;
  reg [7:0]  handling_seen_reg;
  reg [31:0] snap0_reg;
  reg [31:0] snap1_reg;
  reg [31:0] snap2_reg;
  reg        pkt_accept_reg;
  reg        data_err_reg;
  reg        cmd_exec_reg;
  reg        op_err_reg;
  reg        lamp_reg;

  wire [15:0] fault_vec;
  wire [15:0] fault_chg;
  wire [31:0] src_vec;
  wire [63:0] map_all;
  wire [7:0]  slot_pulse;
  wire        q_empty;
  wire        q_full;
  wire [3:0]  q_count;
  wire [2:0]  q_head;
  wire        push;
  wire        lost_evt;
  wire        diag_evt;
  wire        capture;
  wire        wr_stb;
  wire        diag_exit;
  wire        lamp_now;
  reg  [2:0]  push_chan;
  reg  [7:0]  code_next;
  // one loop index per process, so no variable has two drivers
  integer     i;
  integer     j;
  integer     k;

  assign fault_vec = {external_fault_i, internal_fault_i};
  assign fault_chg = fault_vec ^ fault_prev_reg;
  assign src_vec   = {status_bit_i, handling_error_i,
                      external_fault_i, internal_fault_i};
  assign map_all   = {map_hi_reg, map_lo_reg};
  assign wr_stb    = cyc_i & stb_i & we_i & ~ack_reg;

  // ---------------------------------------------------------------
  // process interrupt slots
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `FIR_SLOTS; g = g + 1) begin : g_slot
      // handling errors have no going edge, so they only fire incoming
      wire is_handling = (map_all[g*8+4 -: 2] == 2'b10);
      fir_slot u_slot (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .src_i   (src_vec),
        .sel_i   (map_all[g*8+4 -: 5]),
        .fall_i  (map_all[g*8+`FIR_MAP_FALL_BIT] & ~is_handling),
        .pulse_o (slot_pulse[g])
      );
    end
  endgenerate

  // lowest slot wins when several fire together; the rest count as lost
  always @* begin
    push_chan = 3'h0;
    for (j = `FIR_SLOTS - 1; j >= 0; j = j - 1) begin
      if (slot_pulse[j]) begin
        push_chan = j[2:0];
      end
    end
  end

  assign push     = ctrl_reg[`FIR_CTRL_PROC_EN] & (|slot_pulse);
  assign lost_evt = push & (q_full |
                    ((slot_pulse & (slot_pulse - 8'h01)) != 8'h00));

  fir_queue u_queue (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .push_i  (push),
    .data_i  (push_chan),
    .pop_i   (proc_handler_exit_i),
    .head_o  (q_head),
    .empty_o (q_empty),
    .full_o  (q_full),
    .count_o (q_count)
  );

  assign proc_irq_o              = ~q_empty;
  assign trigger_channel_field_o = q_head;

  // ---------------------------------------------------------------
  // diagnostic interrupt
  // ---------------------------------------------------------------
  assign diag_evt  = ctrl_reg[`FIR_CTRL_DIAG_EN] &
                     ((fault_chg != 16'h0000) | lost_evt);
  assign diag_exit = dstate_reg[1] & diag_handler_exit_i;
  assign capture   = dstate_reg[0] & (diag_evt | dirty_reg);

  // code of the lowest changed fault, top bit set while it is active
  always @* begin
    code_next = code_reg;
    for (k = 15; k >= 0; k = k - 1) begin
      if (fault_chg[k]) begin
        code_next = {fault_vec[k],
                     (k < 8) ? `FIR_KIND_INTERNAL : `FIR_KIND_EXTERNAL,
                     1'b0, k[2:0]};
      end
    end
  end

  always @* begin
    case (dstate_reg)
      ST_IDLE: dstate_next = capture ? ST_PEND : ST_IDLE;
      ST_PEND: dstate_next = diag_exit ? ST_IDLE : ST_PEND;
      default: dstate_next = ST_IDLE;
    endcase
  end

  assign lamp_now = (|fault_vec) | supply_short_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      dstate_reg        <= ST_IDLE;
      dirty_reg         <= 1'b0;
      fault_prev_reg    <= 16'h0000;
      code_reg          <= 8'h00;
      handling_seen_reg <= 8'h00;
      snap0_reg         <= 32'h0000_0000;
      snap1_reg         <= 32'h0000_0000;
      snap2_reg         <= 32'h0000_0000;
      lamp_reg          <= 1'b0;
    end else begin
      dstate_reg     <= dstate_next;
      fault_prev_reg <= fault_vec;
      code_reg       <= code_next;
      lamp_reg       <= lamp_now;
      // changes seen during handling re-raise after the exit
      if (capture) begin
        dirty_reg <= 1'b0;
      end else if (dstate_reg[1] & diag_evt) begin
        dirty_reg <= 1'b1;
      end
      // new handling errors win over the clear at handler exit
      handling_seen_reg <= (diag_exit ? 8'h00 : handling_seen_reg) |
                           handling_error_i;
      if (capture) begin
        snap0_reg <= {8'h00, code_next, 4'h0, `FIR_MODULE_TYPE,
                      4'h0, lost_reg | lost_evt, |external_fault_i,
                      |internal_fault_i, lamp_now};
        snap1_reg <= {16'h0000, handling_seen_reg | handling_error_i,
                      4'h0, q_count};
        snap2_reg <= {16'h0000, fault_vec};
      end
    end
  end

  assign diag_irq_o           = dstate_reg[1];
  assign handler_diag_bytes_o = snap0_reg;
  assign group_fault_lamp_o   = lamp_reg;

  // ---------------------------------------------------------------
  // synchronous messages
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      pkt_accept_reg <= 1'b0;
      data_err_reg   <= 1'b0;
      cmd_exec_reg   <= 1'b0;
      op_err_reg     <= 1'b0;
    end else begin
      pkt_accept_reg <= pkt_valid_i & pkt_plausible_i;
      data_err_reg   <= pkt_valid_i & ~pkt_plausible_i;
      cmd_exec_reg   <= cmd_valid_i & cmd_allowed_i;
      op_err_reg     <= cmd_valid_i & ~cmd_allowed_i;
    end
  end

  assign pkt_accept_o      = pkt_accept_reg;
  assign data_error_o      = data_err_reg;
  assign cmd_execute_o     = cmd_exec_reg;
  assign operating_error_o = op_err_reg;

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg   <= `FIR_CTRL_RESET;
      map_lo_reg <= `FIR_MAP_RESET;
      map_hi_reg <= `FIR_MAP_RESET;
      lost_reg   <= 1'b0;
    end else begin
      if (wr_stb && adr_i == `FIR_ADR_CTRL && sel_i[0]) begin
        ctrl_reg <= dat_i[1:0];
      end
      if (wr_stb && adr_i == `FIR_ADR_MAP_LO) begin
        for (i = 0; i < 4; i = i + 1) begin
          if (sel_i[i]) begin
            map_lo_reg[i*8 +: 8] <= dat_i[i*8 +: 8];
          end
        end
      end
      if (wr_stb && adr_i == `FIR_ADR_MAP_HI) begin
        for (i = 0; i < 4; i = i + 1) begin
          if (sel_i[i]) begin
            map_hi_reg[i*8 +: 8] <= dat_i[i*8 +: 8];
          end
        end
      end
      // write one clears, a lost event in the same cycle wins
      if (lost_evt) begin
        lost_reg <= 1'b1;
      end else if (wr_stb && adr_i == `FIR_ADR_STATUS && sel_i[0] &&
                   dat_i[`FIR_STAT_LOST_BIT]) begin
        lost_reg <= 1'b0;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
      case (adr_i)
        `FIR_ADR_CTRL:   rdata_reg <= {30'h0, ctrl_reg};
        `FIR_ADR_MAP_LO: rdata_reg <= map_lo_reg;
        `FIR_ADR_MAP_HI: rdata_reg <= map_hi_reg;
        `FIR_ADR_DIAG0:  rdata_reg <= snap0_reg;
        `FIR_ADR_DIAG1:  rdata_reg <= snap1_reg;
        `FIR_ADR_DIAG2:  rdata_reg <= snap2_reg;
        `FIR_ADR_DIAG3:  rdata_reg <= 32'h0000_0000;
        `FIR_ADR_STATUS: rdata_reg <= {24'h0, diag_irq_o, lamp_reg,
                                       lost_reg, 1'b0, q_count};
        default:         rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;

endmodule // fir_reporter

`default_nettype wire

// file: fir_reporter_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module fir_reporter_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  adr_i,
  input wire logic        we_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [7:0]  internal_fault_i,
  input wire logic [7:0]  external_fault_i,
  input wire logic        supply_short_i,
  input wire logic        pkt_valid_i,
  input wire logic        pkt_plausible_i,
  input wire logic        cmd_valid_i,
  input wire logic        cmd_allowed_i,
  input wire logic        pkt_accept_o,
  input wire logic        data_error_o,
  input wire logic        cmd_execute_o,
  input wire logic        operating_error_o,
  input wire logic        diag_irq_o,
  input wire logic        diag_handler_exit_i,
  input wire logic [31:0] handler_diag_bytes_o,
  input wire logic        proc_irq_o,
  input wire logic        proc_handler_exit_i,
  input wire logic [2:0]  trigger_channel_field_o,
  input wire logic        group_fault_lamp_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // helper state
  // ----------------------------------------
  // conservative: any control write counts, even one that enables nothing
  logic ctrl_seen_reg;
  wire  any_fault = |internal_fault_i | |external_fault_i | supply_short_i;

  always_ff @(posedge clk_i)
    if (rst_i)
      ctrl_seen_reg <= 1'b0;
    else if (cyc_i && stb_i && we_i && adr_i == 8'h00)
      ctrl_seen_reg <= 1'b1;

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_bus_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_ack_once; ack_o ##1 !ack_o; endsequence
  sequence s_diag_exit; diag_irq_o && diag_handler_exit_i; endsequence

  property p_bus_ack; s_bus_req |=> s_ack_once; endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus ack late");
  property p_quiet; !ctrl_seen_reg |-> !diag_irq_o && !proc_irq_o; endproperty
  a_quiet: assert property (p_quiet) else $error("irq before enable");
  property p_pkt_bad; pkt_valid_i && !pkt_plausible_i
    |=> data_error_o && !pkt_accept_o; endproperty
  a_pkt_bad: assert property (p_pkt_bad) else $error("no data error");
  property p_pkt_ok; pkt_valid_i && pkt_plausible_i
    |=> pkt_accept_o && !data_error_o; endproperty
  a_pkt_ok: assert property (p_pkt_ok) else $error("package lost");
  property p_cmd_bad; cmd_valid_i && !cmd_allowed_i
    |=> operating_error_o && !cmd_execute_o; endproperty
  a_cmd_bad: assert property (p_cmd_bad) else $error("no op error");
  property p_lamp_on; any_fault |=> group_fault_lamp_o; endproperty
  a_lamp_on: assert property (p_lamp_on) else $error("lamp dark");
  property p_lamp_off; !any_fault |=> !group_fault_lamp_o; endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp stuck");
  property p_short; supply_short_i |=> group_fault_lamp_o; endproperty
  a_short: assert property (p_short) else $error("short not lit");
  property p_frozen; diag_irq_o && !diag_handler_exit_i
    |=> diag_irq_o && $stable(handler_diag_bytes_o); endproperty
  a_frozen: assert property (p_frozen) else $error("diag data moved");
  property p_diag_ack; s_diag_exit |=> !diag_irq_o; endproperty
  a_diag_ack: assert property (p_diag_ack) else $error("diag not acked");
  property p_proc_hold; proc_irq_o && !proc_handler_exit_i
    |=> proc_irq_o && $stable(trigger_channel_field_o); endproperty
  a_proc_hold: assert property (p_proc_hold) else $error("proc moved");
endmodule // fir_reporter_asserts

`default_nettype wire

// file: fir_reporter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end \
end

module fir_reporter_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic        we_i = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic [7:0]  internal_fault_i = 8'h00;
  logic [7:0]  external_fault_i = 8'h00;
  logic [7:0]  handling_error_i = 8'h00;
  logic [7:0]  status_bit_i = 8'h00;
  logic        supply_short_i = 1'b0;
  logic        pkt_valid_i = 1'b0;
  logic        pkt_plausible_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic        cmd_allowed_i = 1'b0;
  logic        host_run = 1'b0;
  logic [3:0]  host_wait = 4'h0;
  logic [31:0] rd_data;
  logic [31:0] snap;
  logic [2:0]  idx;
  wire  [31:0] dat_o;
  wire  [31:0] handler_diag_bytes_o;
  wire  [2:0]  trigger_channel_field_o;
  wire         ack_o, pkt_accept_o, data_error_o, cmd_execute_o;
  wire         operating_error_o, diag_irq_o, proc_irq_o;
  wire         group_fault_lamp_o, diag_handler_exit_i, proc_handler_exit_i;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          exp_q[$];

  fir_reporter dut_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i,
    .cyc_i, .stb_i, .ack_o, .internal_fault_i, .external_fault_i,
    .handling_error_i, .status_bit_i, .supply_short_i, .pkt_valid_i,
    .pkt_plausible_i, .cmd_valid_i, .cmd_allowed_i, .pkt_accept_o,
    .data_error_o, .cmd_execute_o, .operating_error_o, .diag_irq_o,
    .diag_handler_exit_i, .handler_diag_bytes_o, .proc_irq_o,
    .proc_handler_exit_i, .trigger_channel_field_o, .group_fault_lamp_o);

  fir_host_model host_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(host_run),
    .wait_i(host_wait), .diag_irq_i(diag_irq_o), .proc_irq_i(proc_irq_o),
    .diag_exit_o(diag_handler_exit_i), .proc_exit_o(proc_handler_exit_i));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= 4'hf;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd_data = dat_o;
    `CHK(ack_o, 1'b1)
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic edges(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic drain;
    int n;
    int exp_v;
    n = 0;
    @(posedge clk_i);
    host_wait <= 4'($urandom_range(6));
    host_run <= 1'b1;
    while (exp_q.size() > 0 && n < 500) begin
      @(posedge clk_i);
      n++;
      if (proc_handler_exit_i === 1'b1) begin
        exp_v = exp_q.pop_front();
        `CHK(trigger_channel_field_o, 3'(exp_v))
      end
    end
    repeat (30) @(negedge clk_i);
    `CHK({exp_q.size() == 0, proc_irq_o, diag_irq_o}, 3'b100)
    // host stops so later scenarios see their events still queued
    @(posedge clk_i);
    host_run <= 1'b0;
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(29280));
    edges(3);
    rst_i <= 1'b0;
    wb(8'h00, 1'b0, 32'h0);
    `CHK(rd_data, 32'h0)
    wb(8'h04, 1'b0, 32'h0);
    `CHK(rd_data, 32'h0)
    wb(8'h40, 1'b1, 32'hffff_ffff);
    wb(8'h40, 1'b0, 32'h0);
    `CHK(rd_data, 32'h0)
    @(posedge clk_i);
    internal_fault_i <= 8'h01;
    repeat (3) @(negedge clk_i);
    `CHK({diag_irq_o, proc_irq_o, group_fault_lamp_o}, 3'b001)
    @(posedge clk_i);
    internal_fault_i <= 8'h00;
    $display("test reset done");

    wb(8'h00, 1'b1, 32'h1);
    idx = 3'($urandom_range(7));
    @(posedge clk_i);
    internal_fault_i <= 8'h01 << idx;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK(diag_irq_o, 1'b1)
    snap = {8'h00, 5'b10010, idx, 16'h0802};
    `CHK(handler_diag_bytes_o & 32'hffff_fffe, snap)
    @(posedge clk_i);
    external_fault_i <= 8'h01;
    edges(4);
    `CHK(handler_diag_bytes_o & 32'hffff_fffe, snap)
    wb(8'h0c, 1'b0, 32'h0);
    `CHK(rd_data & 32'hffff_fffe, snap)
    wb(8'h14, 1'b0, 32'h0);
    `CHK(rd_data, {24'h0, 8'h01 << idx})
    host_wait <= 4'($urandom_range(6));
    host_run <= 1'b1;
    edges(40);
    `CHK(diag_irq_o, 1'b0)
    host_run <= 1'b0;
    internal_fault_i <= 8'h00;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK(diag_irq_o, 1'b1)
    `CHK(handler_diag_bytes_o[23:16], {5'b00010, idx})
    `CHK(group_fault_lamp_o, 1'b1)
    @(posedge clk_i);
    external_fault_i <= 8'h00;
    host_run <= 1'b1;
    edges(40);
    `CHK({diag_irq_o, group_fault_lamp_o}, 2'b00)
    supply_short_i <= 1'b1;
    edges(2);
    @(negedge clk_i);
    `CHK(group_fault_lamp_o, 1'b1)
    @(posedge clk_i);
    supply_short_i <= 1'b0;
    host_run <= 1'b0;
    $display("test diagnostics done");

    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      pkt_valid_i <= 1'b1;
      pkt_plausible_i <= i[0];
      cmd_valid_i <= 1'b1;
      cmd_allowed_i <= i[1];
      @(posedge clk_i);
      pkt_valid_i <= 1'b0;
      cmd_valid_i <= 1'b0;
      @(negedge clk_i);
      `CHK({pkt_accept_o, data_error_o}, {i[0], ~i[0]})
      `CHK({cmd_execute_o, operating_error_o}, {i[1], ~i[1]})
      @(negedge clk_i);
      `CHK({pkt_accept_o, cmd_execute_o}, 2'b00)
    end
    $display("test sync done");

    wb(8'h04, 1'b1, 32'h1b1a_1918);
    wb(8'h08, 1'b1, 32'h1f1e_1d1c);
    wb(8'h00, 1'b1, 32'h3);
    repeat (9) begin
      idx = 3'($urandom_range(7));
      if (exp_q.size() < 8)
        exp_q.push_back(int'(idx));
      @(posedge clk_i);
      status_bit_i <= 8'h01 << idx;
      edges(2);
      status_bit_i <= 8'h00;
      edges(2);
    end
    wb(8'h1c, 1'b0, 32'h0);
    `CHK(rd_data[5:0], 6'h28)
    `CHK(diag_irq_o, 1'b1)
    drain();
    $display("test queue done");

    wb(8'h04, 1'b1, 32'h1b28_1918);
    wb(8'h08, 1'b1, 32'h1f1e_101c);
    external_fault_i <= 8'h01;
    edges(3);
    external_fault_i <= 8'h00;
    edges(3);
    handling_error_i <= 8'h01;
    @(posedge clk_i);
    handling_error_i <= 8'h00;
    exp_q = '{2, 5};
    wb(8'h1c, 1'b1, 32'h20);
    wb(8'h1c, 1'b0, 32'h0);
    `CHK(rd_data[5:0], 6'h02)
    drain();
    $display("test remap done");
    final_report();
  end

  initial begin
    #2000000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule // fir_reporter_tb

bind fir_reporter fir_reporter_asserts u_chk (.clk_i, .rst_i, .adr_i, .we_i,
  .cyc_i, .stb_i, .ack_o, .internal_fault_i, .external_fault_i,
  .supply_short_i, .pkt_valid_i, .pkt_plausible_i, .cmd_valid_i,
  .cmd_allowed_i, .pkt_accept_o, .data_error_o, .cmd_execute_o,
  .operating_error_o, .diag_irq_o, .diag_handler_exit_i,
  .handler_diag_bytes_o, .proc_irq_o, .proc_handler_exit_i,
  .trigger_channel_field_o, .group_fault_lamp_o);

`default_nettype wire

// file: fir_slot.v
`timescale 1ns/1ps
`default_nettype none

// one process interrupt slot: selects a source and fires on one edge
module fir_slot (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [31:0] src_i,
  input  wire [4:0]  sel_i,
  input  wire        fall_i,
  output wire        pulse_o
);

  reg       level_reg;
  reg [4:0] sel_reg;
  wire      level;

  assign level = src_i[sel_i];

  always @(posedge clk_i) begin
    if (rst_i) begin
      level_reg <= 1'b0;
      sel_reg   <= 5'h00;
    end else begin
      level_reg <= level;
      sel_reg   <= sel_i;
    end
  end

  // a remap would look like an edge, so the first cycle after it is quiet
  assign pulse_o = (sel_reg == sel_i) &&
                   (fall_i ? (level_reg & ~level)
                           : (~level_reg & level));

endmodule // fir_slot

`default_nettype wire
